// *** uart_control_status_baud_gen.sv ***
// Control and status registers plus baud rate generator of a serial port.
// Assumes transmit and receive data paths on the same clock drive the status
// inputs as one-cycle pulses or levels, and take the control outputs directly.
`timescale 1ns/100ps

// Summary of operation
// - In synchronous mode clock source bit picks master (1) or slave (0).
// - Transmit width bit selects nine data bits when set, eight when clear.
// - Transmit enable on/off; in synchronous mode receive enables override it.
// - Mode bit selects synchronous when 1, asynchronous when 0.
// - Asynchronous break request sends a break; hardware clears it when sent.
// - Read-only shift-empty bit shows transmit shift register empty; resets to 1.
// - Transmit ninth-bit field supplies the ninth bit in nine-bit mode.
// - Port enable turns the pins over to the port; clear holds port reset.
// - Synchronous master single receive starts one reception, cleared when done.
// - Continuous receive enables receiver; in synchronous mode overrides single.
// - Address detection in async nine-bit mode accepts only characters whose ninth bit is set.
// - Framing error bit updates when the next valid character is taken.
// - Overrun error bit sets on overrun, clears when continuous receive clears.
// - Received ninth bit is stored raw; software checks parity or address.
// - Asynchronous auto-baud overflow bit sets when the auto-baud timer overflows.
// - Receiver idle flag reads 1 while idle or in sync mode, 0 while receiving async; resets to 1.
// - Polarity inverts async transmit data, or picks sync clock edge.
// - Generator width bit selects sixteen-bit divisor; eight-bit after reset.
// - Wake-up waits for falling receive edge, raises receive event, then clears.
// - Auto-baud enable starts detection; hardware clears it on completion.
// - Free-running generator period set by divisor pair and mode bits.
// - Any divisor write restarts the generator timer from zero.
// - Rates are clock/64(n+1), clock/16(n+1), clock/4(n+1) in synchronous or async high-speed sixteen-bit mode.
module uart_control_status_baud_gen (
   input  wire logic                            i_core_clk,          // Core clock.
   input  wire logic                            i_srst,              // Sync reset.
   input  wire logic [uart_csr_pkg::ADDR_W-1:0] i_addr,              // Register index.
   input  wire logic [uart_csr_pkg::DATA_W-1:0] i_wdata,             // Write data.
   input  wire logic                            i_wr,                // Write strobe.
   input  wire logic                            i_rd,                // Read strobe.
   output logic      [uart_csr_pkg::DATA_W-1:0] o_rdata,             // Read data.
   input  wire logic                            i_rx_pin,            // Receive pin.
   input  wire logic                            i_tx_shift_empty,    // Shifter empty.
   input  wire logic                            i_break_done,        // Break sent.
   input  wire logic                            i_rx_busy,           // Receiving.
   input  wire logic                            i_rx_char_done,      // Char received.
   input  wire logic                            i_rx_ninth,          // Its ninth bit.
   input  wire logic                            i_rx_frame_err,      // Its stop bad.
   input  wire logic                            i_rx_overrun,        // Third char.
   input  wire logic                            i_autobaud_done,     // Detect done.
   input  wire logic                            i_autobaud_overflow, // Timer overflow.
   output logic                                 o_port_enable,       // Port on.
   output logic                                 o_sync_mode,         // Synchronous.
   output logic                                 o_sync_master,       // Drive clock.
   output logic                                 o_tx_enable,         // Transmitter on.
   output logic                                 o_tx_nine,           // Nine-bit send.
   output logic                                 o_tx_ninth_bit,      // Ninth tx bit.
   output logic                                 o_send_break,        // Break next.
   output logic                                 o_tx_invert,         // Invert tx data.
   output logic                                 o_sync_clk_rising,   // Rising edge.
   output logic                                 o_rx_enable,         // Receiver on.
   output logic                                 o_rx_nine,           // Nine-bit rcv.
   output logic                                 o_rx_load,           // Take char.
   output logic                                 o_rx_event,          // Receive event.
   output logic                                 o_autobaud_active,   // Detecting.
   output logic                                 o_baud_tick          // Generator step.
);
   import uart_csr_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] tx_ctl;
      logic [DATA_W-1:0] rx_ctl;
      logic [DATA_W-1:0] baud_ctl;
      logic [DATA_W-1:0] div_lo;
      logic [DATA_W-1:0] div_hi;
      logic [CNT_W-1:0]  cnt;
      logic              tick;
      logic [DATA_W-1:0] rdata;
      logic              rx_meta;
      logic              rx_sync;
      logic              rx_prev;
      logic              rx_load;
      logic              rx_event;
   } csr_state_t;

   csr_state_t st;
   csr_state_t next_st;

   logic              port_en;
   logic              sync_mode;
   logic              master;
   logic              cont_rx;
   logic              single_rx;
   logic              wake_armed;
   logic              wake_edge;
   logic              addr_reject;
   logic              accept;
   logic              div_wr;
   logic [15:0]       divisor;
   logic [2:0]        shift;
   logic [CNT_W-1:0]  limit;

   assign port_en   = st.rx_ctl[RX_PORT_EN];
   assign sync_mode = st.tx_ctl[TX_SYNC];
   assign master    = sync_mode & st.tx_ctl[TX_CLK_SRC];
   assign cont_rx   = st.rx_ctl[RX_CONT];
   // Single receive only counts as a synchronous master.
   assign single_rx = master & st.rx_ctl[RX_SINGLE];
   assign wake_armed = port_en & ~sync_mode & st.baud_ctl[BD_WAKEUP];
   // Edge detect looks at the second synchroniser stage and its delayed copy.
   assign wake_edge = wake_armed & st.rx_prev & ~st.rx_sync;
   assign addr_reject = ~sync_mode & st.rx_ctl[RX_NINE]
                      & st.rx_ctl[RX_ADDR_DET] & ~i_rx_ninth;
   assign accept = i_rx_char_done & port_en & ~wake_armed & ~addr_reject;
   assign div_wr = i_wr & ((i_addr == OFF_DIV_LO) | (i_addr == OFF_DIV_HI));

   // The high byte only counts in sixteen-bit mode.
   assign divisor = st.baud_ctl[BD_WIDTH16] ? {st.div_hi, st.div_lo}
                                            : {DIV_RST, st.div_lo};

   always_comb begin
      if (sync_mode) begin
         shift = SH_DIV4;
      end else if (st.baud_ctl[BD_WIDTH16]) begin
         shift = st.tx_ctl[TX_HIGH_SPEED] ? SH_DIV4 : SH_DIV16;
      end else begin
         shift = st.tx_ctl[TX_HIGH_SPEED] ? SH_DIV16 : SH_DIV64;
      end
   end

   assign limit = ((CNT_W'(divisor) + CNT_ONE) << shift) - CNT_ONE;

   always_comb begin
      next_st = st;
      next_st.rdata    = READ_IDLE;
      next_st.tick     = 1'b0;
      next_st.rx_load  = 1'b0;
      next_st.rx_event = 1'b0;
      next_st.rx_meta  = i_rx_pin;
      next_st.rx_sync  = st.rx_meta;
      next_st.rx_prev  = st.rx_sync;

      // Register read, answered in the following cycle only.
      if (i_rd) begin
         if (i_addr == OFF_TX_CTL) begin
            next_st.rdata = st.tx_ctl;
         end else if (i_addr == OFF_RX_CTL) begin
            next_st.rdata = st.rx_ctl;
         end else if (i_addr == OFF_BAUD_CTL) begin
            next_st.rdata = st.baud_ctl;
         end else if (i_addr == OFF_DIV_LO) begin
            next_st.rdata = st.div_lo;
         end else if (i_addr == OFF_DIV_HI) begin
            next_st.rdata = st.div_hi;
         end else begin
            next_st.rdata = READ_IDLE;
         end
      end

      // Hardware clears of request bits come first so a same-cycle write wins.
      if (i_break_done) begin
         next_st.tx_ctl[TX_BREAK] = 1'b0;
      end
      if (i_autobaud_done) begin
         next_st.baud_ctl[BD_AUTOBAUD] = 1'b0;
      end
      if (i_rx_char_done & single_rx & ~cont_rx) begin
         next_st.rx_ctl[RX_SINGLE] = 1'b0;
      end
      if (wake_edge) begin
         next_st.baud_ctl[BD_WAKEUP] = 1'b0;
         next_st.rx_event = 1'b1;
      end

      // Register write; status bits keep their value through the mask.
      if (i_wr) begin
         if (i_addr == OFF_TX_CTL) begin
            next_st.tx_ctl = (next_st.tx_ctl & ~TX_WR_MASK) | (i_wdata & TX_WR_MASK);
         end else if (i_addr == OFF_RX_CTL) begin
            next_st.rx_ctl = (next_st.rx_ctl & ~RX_WR_MASK) | (i_wdata & RX_WR_MASK);
         end else if (i_addr == OFF_BAUD_CTL) begin
            next_st.baud_ctl = (next_st.baud_ctl & ~BD_WR_MASK)
                             | (i_wdata & BD_WR_MASK);
            // A fresh detection starts with the overflow flag cleared.
            if (i_wdata[BD_AUTOBAUD]) begin
               next_st.baud_ctl[BD_AB_OVF] = 1'b0;
            end
         end else if (i_addr == OFF_DIV_LO) begin
            next_st.div_lo = i_wdata;
         end else if (i_addr == OFF_DIV_HI) begin
            next_st.div_hi = i_wdata;
         end
      end

      // Status mirrors.
      next_st.tx_ctl[TX_SHIFT_EMPTY] = i_tx_shift_empty;
      next_st.baud_ctl[BD_RX_IDLE] = sync_mode | ~i_rx_busy;

      // Taken character: its framing and ninth bit are kept as they came.
      if (accept) begin
         next_st.rx_ctl[RX_FRAME_ERR] = i_rx_frame_err;
         next_st.rx_ctl[RX_NINTH] = i_rx_ninth;
         next_st.rx_load  = 1'b1;
         next_st.rx_event = 1'b1;
      end

      // Overrun only lives while continuous receive stays on.
      if (~cont_rx | ~port_en) begin
         next_st.rx_ctl[RX_OVERRUN] = 1'b0;
      end
      if (i_rx_overrun & cont_rx & port_en) begin
         next_st.rx_ctl[RX_OVERRUN] = 1'b1;
      end
      if (i_autobaud_overflow & ~sync_mode & st.baud_ctl[BD_AUTOBAUD]) begin
         next_st.baud_ctl[BD_AB_OVF] = 1'b1;
      end

      // Free-running generator; the compare uses >= so a smaller divisor or
      // a faster mode never leaves the counter stranded above the limit.
      if (div_wr | ~port_en) begin
         next_st.cnt = CNT_ZERO;
      end else if (st.cnt >= limit) begin
         next_st.cnt  = CNT_ZERO;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + CNT_ONE;
      end

      // A disabled port drops its error state and any pending events.
      if (~port_en) begin
         next_st.rx_ctl[RX_FRAME_ERR] = 1'b0;
         next_st.rx_load  = 1'b0;
         next_st.rx_event = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st          <= '0;
         st.tx_ctl   <= TX_RST;
         st.rx_ctl   <= RX_RST;
         st.baud_ctl <= BD_RST;
         st.rx_meta  <= 1'b1;
         st.rx_sync  <= 1'b1;
         st.rx_prev  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata           = st.rdata;
   assign o_port_enable     = port_en;
   assign o_sync_mode       = sync_mode;
   assign o_sync_master     = port_en & master;
   assign o_tx_enable       = port_en & st.tx_ctl[TX_EN]
                            & ~(sync_mode & (cont_rx | single_rx));
   assign o_tx_nine         = st.tx_ctl[TX_NINE];
   assign o_tx_ninth_bit    = st.tx_ctl[TX_NINTH];
   assign o_send_break      = port_en & ~sync_mode & st.tx_ctl[TX_BREAK];
   assign o_tx_invert       = ~sync_mode & st.baud_ctl[BD_POLARITY];
   assign o_sync_clk_rising = sync_mode & st.baud_ctl[BD_POLARITY];
   // Wake-up mode keeps the receiver from taking characters.
   assign o_rx_enable       = port_en & (sync_mode ? (cont_rx | single_rx)
                                         : (cont_rx & ~wake_armed));
   assign o_rx_nine         = st.rx_ctl[RX_NINE];
   assign o_rx_load         = st.rx_load;
   assign o_rx_event        = st.rx_event;
   assign o_autobaud_active = port_en & ~sync_mode & st.baud_ctl[BD_AUTOBAUD];
   assign o_baud_tick       = st.tick;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   // Generator checks. The smallest limit is three, so ticks never touch.

   AST_DIV_WRITE_RESTART: assert property (div_wr |=> st.cnt == CNT_ZERO && !o_baud_tick)
      else $error("Divisor write did not restart the generator.");

   AST_TICK_AT_LIMIT: assert property (port_en && !div_wr && st.cnt == limit
                                       |=> o_baud_tick && st.cnt == CNT_ZERO)
      else $error("Generator did not step at its limit.");

   AST_TICK_ONE_CYCLE: assert property (o_baud_tick |=> !o_baud_tick)
      else $error("Generator tick stood longer than one cycle.");

   AST_RATE_SHIFT: assert property (sync_mode |-> shift == SH_DIV4)
      else $error("Synchronous mode not dividing by four.");

   // Port enable checks.

   AST_PORT_OFF_HOLDS: assert property (!port_en |=> st.cnt == CNT_ZERO
                                       && !st.rx_ctl[RX_OVERRUN] && !o_tx_enable)
      else $error("Disabled port is not held in reset.");

   AST_PORT_OFF_QUIET: assert property (!port_en
                                        |=> !o_baud_tick && !o_rx_load)
      else $error("Disabled port still produced a tick or a load.");

   // Control bits and their hardware clears.

   AST_SYNC_TX_OVERRIDE: assert property (sync_mode && cont_rx |-> !o_tx_enable)
      else $error("Receive enable did not override transmit in sync mode.");

   AST_BREAK_CLEAR: assert property (i_break_done && !(i_wr && i_addr == OFF_TX_CTL)
                                     |=> !st.tx_ctl[TX_BREAK])
      else $error("Break request not cleared after the break.");

   AST_AUTOBAUD_CLEAR: assert property (i_autobaud_done && !(i_wr && i_addr == OFF_BAUD_CTL)
                                        |=> !st.baud_ctl[BD_AUTOBAUD])
      else $error("Auto-baud enable not cleared on completion.");

   AST_OVF_SET: assert property (i_autobaud_overflow && !sync_mode
                                 && st.baud_ctl[BD_AUTOBAUD]
                                 |=> st.baud_ctl[BD_AB_OVF])
      else $error("Auto-baud overflow was not recorded.");

   // Read data and status mirrors lag their inputs by exactly one cycle.

   AST_READ_ONE_CYCLE: assert property (!i_rd |=> o_rdata == READ_IDLE)
      else $error("Read data stood outside its cycle.");

   AST_SHIFT_MIRROR: assert property (1'b1
                                      |=> st.tx_ctl[TX_SHIFT_EMPTY] == $past(i_tx_shift_empty))
      else $error("Shift-empty status does not follow the transmit path.");

   AST_IDLE_MIRROR: assert property (1'b1 |=> st.baud_ctl[BD_RX_IDLE]
                                     == ($past(sync_mode) || !$past(i_rx_busy)))
      else $error("Receiver idle flag does not follow the receive path.");

   // Receive path checks.

   AST_ADDR_FILTER: assert property (i_rx_char_done && addr_reject
                                     |=> !o_rx_load && !st.rx_event)
      else $error("Character without address bit was taken.");

   AST_LOAD_WITH_EVENT: assert property (o_rx_load |-> o_rx_event)
      else $error("Load without a receive event.");

   AST_FRAME_TAKEN: assert property (accept |=> st.rx_ctl[RX_FRAME_ERR] == $past(i_rx_frame_err)
                                     && st.rx_ctl[RX_NINTH] == $past(i_rx_ninth))
      else $error("Taken character status was not stored.");

   AST_OVERRUN_SET: assert property (i_rx_overrun && cont_rx && port_en
                                     |=> st.rx_ctl[RX_OVERRUN])
      else $error("Overrun was not recorded.");

   AST_OVERRUN_CLEAR: assert property ($fell(cont_rx) |-> ##1 !st.rx_ctl[RX_OVERRUN])
      else $error("Overrun survived clearing continuous receive.");

   AST_SINGLE_CLEAR: assert property (i_rx_char_done && single_rx && !cont_rx
                                      && !(i_wr && i_addr == OFF_RX_CTL)
                                      |=> !st.rx_ctl[RX_SINGLE])
      else $error("Single receive not cleared after its character.");

   AST_WAKE_EVENT: assert property (wake_edge && !i_wr
                                    |=> o_rx_event && !st.baud_ctl[BD_WAKEUP])
      else $error("Wake-up edge did not raise the event and clear itself.");

endmodule : uart_control_status_baud_gen

// *** uart_control_status_baud_gen_tb_top.sv ***
// Self-checking bench for the serial port control block and baud generator.
// Assumes the path model drives all status inputs; registers go over the plain port.
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t %s", $time, m); end end
module uart_control_status_baud_gen_tb_top;
   import uart_csr_pkg::*;
   logic i_core_clk = 1'h0, i_srst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
   logic [ADDR_W-1:0] i_addr = 3'h0;
   logic [DATA_W-1:0] i_wdata = 8'h00, o_rdata, d;
   logic i_rx_pin, i_tx_shift_empty, i_break_done, i_rx_busy, i_rx_char_done, i_rx_ninth;
   logic i_rx_frame_err, i_rx_overrun, i_autobaud_done, i_autobaud_overflow;
   logic o_port_enable, o_sync_mode, o_sync_master, o_tx_enable, o_tx_nine, o_tx_ninth_bit;
   logic o_send_break, o_tx_invert, o_sync_clk_rising, o_rx_enable, o_rx_nine, o_rx_load;
   logic o_rx_event, o_autobaud_active, o_baud_tick, seen;
   int errors = 0;
   int n_checks = 0;
   int c;
   localparam logic [7:0] RST_V [8] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] T_TX [6] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h04, 8'h04};
   localparam logic [7:0] T_BD [6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h08};
   localparam logic [7:0] T_LO [6] = '{8'h00, 8'h02, 8'h01, 8'h02, 8'h01, 8'h00};
   localparam logic [7:0] T_HI [6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
   localparam int T_P [6] = '{4, 12, 128, 48, 32, 1028};
   always #5 i_core_clk = ~i_core_clk;
   uart_control_status_baud_gen uart_control_status_baud_gen_inst (
      .i_core_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rx_pin,
      .i_tx_shift_empty, .i_break_done, .i_rx_busy, .i_rx_char_done, .i_rx_ninth,
      .i_rx_frame_err, .i_rx_overrun, .i_autobaud_done, .i_autobaud_overflow,
      .o_port_enable, .o_sync_mode, .o_sync_master, .o_tx_enable, .o_tx_nine,
      .o_tx_ninth_bit, .o_send_break, .o_tx_invert, .o_sync_clk_rising, .o_rx_enable,
      .o_rx_nine, .o_rx_load, .o_rx_event, .o_autobaud_active, .o_baud_tick);
   uart_path_model uart_path_model_inst (
      .i_core_clk, .o_shift_empty(i_tx_shift_empty), .o_rx_busy(i_rx_busy),
      .o_char_done(i_rx_char_done), .o_ninth(i_rx_ninth), .o_frame_err(i_rx_frame_err),
      .o_pin(i_rx_pin), .o_break_done(i_break_done), .o_overrun(i_rx_overrun),
      .o_ab_done(i_autobaud_done), .o_ab_ovf(i_autobaud_overflow));
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge i_core_clk);
      i_addr  <= a;
      i_wdata <= v;
      i_wr    <= 1'h1;
      @(posedge i_core_clk);
      i_wr <= 1'h0;
      #1;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd   <= 1'h1;
      @(posedge i_core_clk);
      i_rd <= 1'h0;
      #1 d = o_rdata;
   endtask : rd
   // Counts edges until the tick is seen; the cap turns a dead generator into a count.
   task automatic ticks;
      c = 0;
      do begin
         @(posedge i_core_clk);
         #1;
         c++;
      end while (o_baud_tick !== 1'h1 && c < 3000);
   endtask : ticks
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      #300000;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_srst <= 1'h0;
      wr(3'h5, 8'hFF);
      foreach (RST_V[k]) begin
         rd(ADDR_W'(k));
         `CHK(d, RST_V[k], "reset or unmapped value")
      end
      $display("test reset done");
      uart_path_model_inst.levels(1'h0, 1'h1, 1'h1);
      wr(OFF_TX_CTL, 8'hFF);
      rd(OFF_TX_CTL);
      `CHK(d, 8'hFD, "shifter full status")
      wr(OFF_BAUD_CTL, 8'hFF);
      rd(OFF_BAUD_CTL);
      `CHK(d, 8'h5B, "idle flag in sync mode")
      wr(OFF_TX_CTL, 8'h00);
      rd(OFF_BAUD_CTL);
      `CHK(d, 8'h1B, "idle flag while busy")
      uart_path_model_inst.levels(1'h1, 1'h0, 1'h1);
      rd(OFF_BAUD_CTL);
      `CHK(d, 8'h5B, "idle flag back")
      wr(OFF_BAUD_CTL, 8'h00);
      $display("test status bits done");
      wr(OFF_RX_CTL, 8'h80);
      wr(OFF_TX_CTL, 8'hE5);
      `CHK({o_sync_master, o_sync_mode, o_tx_enable, o_tx_nine, o_tx_ninth_bit}, 5'h07, "async")
      wr(OFF_RX_CTL, 8'h90);
      wr(OFF_TX_CTL, 8'hB0);
      `CHK({o_sync_master, o_sync_mode, o_tx_enable, o_tx_nine, o_rx_enable}, 5'h19, "sync")
      wr(OFF_BAUD_CTL, 8'h10);
      `CHK({o_tx_invert, o_sync_clk_rising}, 2'h1, "sync clock edge")
      wr(OFF_TX_CTL, 8'h00);
      `CHK({o_tx_invert, o_sync_clk_rising, o_rx_enable}, 3'h5, "async invert")
      wr(OFF_TX_CTL, 8'h08);
      `CHK(o_send_break, 1'h1, "break requested")
      uart_path_model_inst.pulse(0);
      rd(OFF_TX_CTL);
      `CHK(d, 8'h02, "break cleared")
      $display("test control outputs done");
      wr(OFF_RX_CTL, 8'hD8);
      `CHK(o_rx_nine, 1'h1, "nine-bit receive")
      uart_path_model_inst.rx_char(1'h0, 1'h1);
      #1 `CHK(o_rx_load, 1'h0, "address char refused")
      uart_path_model_inst.rx_char(1'h1, 1'h1);
      #1 `CHK({o_rx_load, o_rx_event}, 2'h3, "address char taken")
      rd(OFF_RX_CTL);
      `CHK(d, 8'hDD, "frame error and ninth bit")
      wr(OFF_RX_CTL, 8'hD0);
      uart_path_model_inst.rx_char(1'h0, 1'h0);
      #1 `CHK(o_rx_load, 1'h1, "data char taken")
      rd(OFF_RX_CTL);
      `CHK(d, 8'hD0, "frame error updated")
      uart_path_model_inst.pulse(1);
      rd(OFF_RX_CTL);
      `CHK(d, 8'hD2, "overrun set")
      wr(OFF_RX_CTL, 8'hC0);
      rd(OFF_RX_CTL);
      `CHK(d, 8'hC0, "overrun cleared")
      wr(OFF_TX_CTL, 8'h90);
      wr(OFF_RX_CTL, 8'hA0);
      uart_path_model_inst.rx_char(1'h0, 1'h0);
      rd(OFF_RX_CTL);
      `CHK(d, 8'h80, "single receive cleared")
      wr(OFF_TX_CTL, 8'h10);
      wr(OFF_RX_CTL, 8'hA0);
      uart_path_model_inst.rx_char(1'h0, 1'h0);
      rd(OFF_RX_CTL);
      `CHK(d, 8'hA0, "single receive kept in slave")
      $display("test receive done");
      wr(OFF_TX_CTL, 8'h00);
      wr(OFF_RX_CTL, 8'h90);
      wr(OFF_BAUD_CTL, 8'h02);
      uart_path_model_inst.levels(1'h1, 1'h0, 1'h0);
      seen = 1'h0;
      repeat (8) begin
         @(posedge i_core_clk);
         #1 seen = seen | o_rx_event;
      end
      `CHK(seen, 1'h1, "wake-up event")
      uart_path_model_inst.levels(1'h1, 1'h0, 1'h1);
      rd(OFF_BAUD_CTL);
      `CHK(d, 8'h40, "wake-up cleared")
      wr(OFF_BAUD_CTL, 8'h01);
      `CHK(o_autobaud_active, 1'h1, "auto-baud active")
      uart_path_model_inst.pulse(3);
      rd(OFF_BAUD_CTL);
      `CHK(d, 8'hC1, "auto-baud overflow")
      uart_path_model_inst.pulse(2);
      rd(OFF_BAUD_CTL);
      `CHK(d, 8'hC0, "auto-baud done")
      $display("test wake-up and auto-baud done");
      wr(OFF_RX_CTL, 8'h80);
      foreach (T_P[k]) begin
         wr(OFF_TX_CTL, T_TX[k]);
         wr(OFF_BAUD_CTL, T_BD[k]);
         wr(OFF_DIV_HI, T_HI[k]);
         wr(OFF_DIV_LO, T_LO[k]);
         ticks();
         ticks();
         `CHK(c, T_P[k], "generator period")
         if (k == 3) begin
            wr(OFF_DIV_LO, T_LO[k]);
            ticks();
            `CHK(c >= T_P[k] && c <= T_P[k] + 2, 1'b1, "restart on write")
         end
      end
      wr(OFF_RX_CTL, 8'h00);
      `CHK(o_port_enable, 1'h0, "port off")
      ticks();
      ticks();
      `CHK(c, 3000, "generator held")
      $display("test baud generator done");
      tally_and_finish();
   end
endmodule : uart_control_status_baud_gen_tb_top

// *** uart_csr_pkg.sv ***
// Register map, field positions, reset values and divider constants of the
// serial port control block.
// Assumes a single 100 MHz core clock shared by the port's data paths.
package uart_csr_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 23;

   localparam logic [ADDR_W-1:0] OFF_TX_CTL   = 3'h0;
   localparam logic [ADDR_W-1:0] OFF_RX_CTL   = 3'h1;
   localparam logic [ADDR_W-1:0] OFF_BAUD_CTL = 3'h2;
   localparam logic [ADDR_W-1:0] OFF_DIV_LO   = 3'h3;
   localparam logic [ADDR_W-1:0] OFF_DIV_HI   = 3'h4;

   // transmit_control_status fields.
   localparam int TX_CLK_SRC     = 7;
   localparam int TX_NINE        = 6;
   localparam int TX_EN          = 5;
   localparam int TX_SYNC        = 4;
   localparam int TX_BREAK       = 3;
   localparam int TX_HIGH_SPEED  = 2;
   localparam int TX_SHIFT_EMPTY = 1;
   localparam int TX_NINTH       = 0;

   // receive_control_status fields.
   localparam int RX_PORT_EN   = 7;
   localparam int RX_NINE      = 6;
   localparam int RX_SINGLE    = 5;
   localparam int RX_CONT      = 4;
   localparam int RX_ADDR_DET  = 3;
   localparam int RX_FRAME_ERR = 2;
   localparam int RX_OVERRUN   = 1;
   localparam int RX_NINTH     = 0;

   // baud_rate_control fields.
   localparam int BD_AB_OVF   = 7;
   localparam int BD_RX_IDLE  = 6;
   localparam int BD_POLARITY = 4;
   localparam int BD_WIDTH16  = 3;
   localparam int BD_WAKEUP   = 1;
   localparam int BD_AUTOBAUD = 0;

   // Bits that software may write; the others are status or unimplemented.
   localparam logic [DATA_W-1:0] TX_WR_MASK = 8'hFD;
   localparam logic [DATA_W-1:0] RX_WR_MASK = 8'hF8;
   localparam logic [DATA_W-1:0] BD_WR_MASK = 8'h1B;

   localparam logic [DATA_W-1:0] TX_RST   = 8'h02;
   localparam logic [DATA_W-1:0] RX_RST   = 8'h00;
   localparam logic [DATA_W-1:0] BD_RST   = 8'h40;
   localparam logic [DATA_W-1:0] DIV_RST  = 8'h00;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

   // Divide by (n+1) shifted left: 64, 16 and 4 clocks per generator step.
   localparam logic [2:0] SH_DIV64 = 3'h6;
   localparam logic [2:0] SH_DIV16 = 3'h4;
   localparam logic [2:0] SH_DIV4  = 3'h2;
   localparam logic [CNT_W-1:0] CNT_ONE  = 23'h000001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 23'h000000;
endpackage : uart_csr_pkg

// *** uart_path_model.sv ***
// Model of the transmit and receive data paths beside the control block.
// Assumes the bench calls its tasks; all changes land just after a rising edge.
`timescale 1ns/100ps
module uart_path_model (
   input  wire logic i_core_clk,    // Core clock.
   output logic      o_shift_empty, // Shifter empty.
   output logic      o_rx_busy,     // Inside a character.
   output logic      o_char_done,   // Character received.
   output logic      o_ninth,       // Its ninth bit.
   output logic      o_frame_err,   // Its stop bit bad.
   output logic      o_pin,         // Receive line, idle high.
   output logic      o_break_done,  // Break sent.
   output logic      o_overrun,     // Third character lost.
   output logic      o_ab_done,     // Detection complete.
   output logic      o_ab_ovf       // Detection timer overflow.
);
   logic [3:0] ev = 4'h0;
   assign o_break_done = ev[0];
   assign o_overrun    = ev[1];
   assign o_ab_done    = ev[2];
   assign o_ab_ovf     = ev[3];
   initial begin
      o_shift_empty = 1'h1;
      o_rx_busy     = 1'h0;
      o_char_done   = 1'h0;
      o_ninth       = 1'h0;
      o_frame_err   = 1'h0;
      o_pin         = 1'h1;
   end
   task automatic pulse(input int k);
      @(posedge i_core_clk);
      ev[k] <= 1'h1;
      @(posedge i_core_clk);
      ev <= 4'h0;
   endtask : pulse
   // The data lines flip once the strobe is gone, so a late sample sees garbage.
   task automatic rx_char(input logic n, input logic f);
      @(posedge i_core_clk);
      o_char_done <= 1'h1;
      o_ninth     <= n;
      o_frame_err <= f;
      @(posedge i_core_clk);
      o_char_done <= 1'h0;
      o_ninth     <= ~n;
      o_frame_err <= ~f;
   endtask : rx_char
   task automatic levels(input logic e, input logic b, input logic p);
      @(posedge i_core_clk);
      o_shift_empty <= e;
      o_rx_busy     <= b;
      o_pin         <= p;
   endtask : levels
endmodule : uart_path_model
